//--- src/rcsc_pkg.sv
// Shared constants for the ROM and I/O chip-select controller
package rcsc_pkg;
   // Number of ROM chip selects
   localparam int NUM_CS = 4;
   // Chip-select index width
   localparam int CS_W = 2;
   // Full memory data width and half width
   localparam int DATA_W = 64;
   localparam int HALF_W = 32;
   // Access latency field width
   localparam int LAT_W = 4;
   // Chip select used for boot fetches
   localparam logic [1:0] BOOT_CS = 2'h0;
   // All chip selects negated (active low)
   localparam logic [3:0] CS_IDLE = 4'hF;
   // Chip selects that support the byte-wide mode
   localparam logic [3:0] BYTE_CS_MASK = 4'h3;
   // Reset value of the boot flag
   localparam logic BOOT_RST = 1'h1;
endpackage

//--- src/rcsc_cycle_timer.sv
`timescale 1ns/1ns
// Counts the cycles of one access and places the address strobe
module rcsc_cycle_timer #(
   parameter int LAT_W = 4
) (
   input wire logic clock_in,
   input wire logic rst_b_in,
   input wire logic start_in,
   input wire logic [LAT_W-1:0] latency_in,
   input wire logic strobe_en_in,
   input wire logic [LAT_W-1:0] strobe_pos_in,
   output logic active_out,
   output logic last_out,
   output logic strobe_out
);
   // Latched latency and strobe slot for the access in flight
   logic [LAT_W-1:0] lat_q;
   logic [LAT_W-1:0] pos_q;
   logic sen_q;
   // Cycle index within the access
   logic [LAT_W-1:0] cnt_q;
   logic [LAT_W-1:0] cnt_d;
   logic act_q;
   logic act_d;
   logic last_w;

   // Final cycle when the count reaches the latched latency
   assign last_w = act_q && (cnt_q == lat_q);
   assign cnt_d = start_in ? '0 : (act_q ? cnt_q + 1'b1 : cnt_q);
   assign act_d = start_in ? 1'b1 : (last_w ? 1'b0 : act_q);

   // Latch timing at start so a rewrite only hits later accesses
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         lat_q <= '0;
         pos_q <= '0;
         sen_q <= 1'b0;
      end else if (start_in) begin
         lat_q <= latency_in;
         pos_q <= strobe_pos_in;
         sen_q <= strobe_en_in;
      end
   end

   // Cycle counter
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_q <= '0;
         act_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         act_q <= act_d;
      end
   end

   assign active_out = act_q;
   assign last_out = last_w;
   // Strobe for one cycle at the chosen slot inside the access
   assign strobe_out = act_q && sen_q && (cnt_q == pos_q);
endmodule

//--- src/rcsc_rom_cs_ctrl.sv
`timescale 1ns/1ns
module rcsc_rom_cs_ctrl #(
   parameter int ADDR_W = 23
) (
   input wire logic clock_in,
   input wire logic rst_b_in,
   // Host access request, taken when idle
   input wire logic req_in,
   input wire logic write_in,
   input wire logic [rcsc_pkg::CS_W-1:0] cs_sel_in,
   input wire logic byte_mode_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [rcsc_pkg::DATA_W-1:0] wdata_in,
   // Configuration levels
   input wire logic [rcsc_pkg::LAT_W-1:0] rom_access_latency_in,
   input wire logic config_done_in,
   input wire logic strobe_en_in,
   input wire logic [rcsc_pkg::LAT_W-1:0] strobe_pos_in,
   // Memory data bus inputs
   input wire logic [rcsc_pkg::HALF_W-1:0] mem_data_upper_half_in,
   input wire logic [rcsc_pkg::HALF_W-1:0] mem_data_lower_half_in,
   // Host answer
   output logic busy_out,
   output logic done_out,
   output logic [rcsc_pkg::DATA_W-1:0] rdata_out,
   // Memory side pins
   output logic [rcsc_pkg::NUM_CS-1:0] rom_chip_select_b_out,
   output logic flash_output_enable_b_out,
   output logic write_enable_b_out,
   output logic mid_cycle_addr_strobe_b_out,
   output logic byte_wide_out,
   output logic [ADDR_W-1:0] mem_addr_out,
   output logic [rcsc_pkg::HALF_W-1:0] mem_data_upper_half_out,
   output logic [rcsc_pkg::HALF_W-1:0] mem_data_lower_half_out,
   output logic mem_data_oe_out
);
   // Reset synchroniser, release through two flops
   logic rst_s1_q;
   logic rst_s2_q;
   logic rst_b;

   // Access state
   typedef enum logic {RCSC_IDLE, RCSC_ACCESS} rcsc_state_t;
   rcsc_state_t state_q;
   rcsc_state_t state_d;

   // Boot flag, cleared once configuration is programmed
   logic boot_q;
   // Latched access attributes
   logic [rcsc_pkg::NUM_CS-1:0] cs_b_q;
   logic oe_b_q;
   logic we_b_q;
   logic byte_q;
   logic [ADDR_W-1:0] addr_q;
   logic [rcsc_pkg::DATA_W-1:0] wdata_q;
   logic [rcsc_pkg::DATA_W-1:0] rdata_q;
   logic done_q;
   logic wr_q;

   // Decode wires
   logic start_w;
   logic [rcsc_pkg::CS_W-1:0] cs_eff_w;
   logic [rcsc_pkg::NUM_CS-1:0] cs_onehot_w;
   logic byte_ok_w;
   logic strobe_ok_w;
   logic t_active;
   logic t_last;
   logic t_strobe;

   // One-hot decode of a chip-select index
   function automatic logic [rcsc_pkg::NUM_CS-1:0] cs_decode(
      input logic [rcsc_pkg::CS_W-1:0] idx
   );
      cs_decode = rcsc_pkg::NUM_CS'(1) << idx;
   endfunction

   // Async assert, clocked release
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_b = rst_s2_q;

   // Take a request only when idle
   assign start_w = req_in && (state_q == RCSC_IDLE);
   // Boot forces every fetch onto the boot chip select
   assign cs_eff_w = boot_q ? rcsc_pkg::BOOT_CS : cs_sel_in;
   assign cs_onehot_w = cs_decode(cs_eff_w);
   // Byte-wide mode only on the first two chip selects
   assign byte_ok_w = byte_mode_in &&
      ((cs_onehot_w & rcsc_pkg::BYTE_CS_MASK) != '0);
   // Strobe timing is unprogrammed while booting
   assign strobe_ok_w = strobe_en_in && !boot_q;

   // Cycle timer shared by every chip select
   rcsc_cycle_timer #(
      .LAT_W(rcsc_pkg::LAT_W)
   ) u_timer (
      .clock_in(clock_in),
      .rst_b_in(rst_b),
      .start_in(start_w),
      .latency_in(rom_access_latency_in),
      .strobe_en_in(strobe_ok_w),
      .strobe_pos_in(strobe_pos_in),
      .active_out(t_active),
      .last_out(t_last),
      .strobe_out(t_strobe)
   );

   // Next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         RCSC_IDLE: begin
            if (req_in) begin
               state_d = RCSC_ACCESS;
            end
         end
         RCSC_ACCESS: begin
            if (t_last) begin
               state_d = RCSC_IDLE;
            end
         end
         default: begin
            state_d = RCSC_IDLE;
         end
      endcase
   end

   // State and boot flag
   always_ff @(posedge clock_in or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= RCSC_IDLE;
         boot_q <= rcsc_pkg::BOOT_RST;
      end else begin
         state_q <= state_d;
         // Boot ends once software has set up the controller
         if (config_done_in) begin
            boot_q <= 1'b0;
         end
      end
   end

   // Pin controls, asserted at start and negated after the last cycle
   always_ff @(posedge clock_in or negedge rst_b) begin
      if (!rst_b) begin
         cs_b_q <= rcsc_pkg::CS_IDLE;
         oe_b_q <= 1'b1;
         we_b_q <= 1'b1;
      end else if (start_w) begin
         cs_b_q <= ~cs_onehot_w;
         oe_b_q <= write_in;
         we_b_q <= !write_in;
      end else if (t_last) begin
         cs_b_q <= rcsc_pkg::CS_IDLE;
         oe_b_q <= 1'b1;
         we_b_q <= 1'b1;
      end
   end

   // Address and write data held for the whole access
   always_ff @(posedge clock_in or negedge rst_b) begin
      if (!rst_b) begin
         addr_q <= '0;
         wdata_q <= '0;
         byte_q <= 1'b0;
         wr_q <= 1'b0;
      end else if (start_w) begin
         addr_q <= addr_in;
         wdata_q <= wdata_in;
         byte_q <= byte_ok_w;
         wr_q <= write_in;
      end
   end

   // Read capture of all lanes on the last cycle
   always_ff @(posedge clock_in or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= '0;
         done_q <= 1'b0;
      end else begin
         done_q <= t_last;
         if (t_last && !wr_q) begin
            // Upper half first: byte 0 lands in the top byte
            rdata_q <= {mem_data_upper_half_in,
                        mem_data_lower_half_in};
         end
      end
   end

   assign busy_out = (state_q != RCSC_IDLE);
   assign done_out = done_q;
   assign rdata_out = rdata_q;
   assign rom_chip_select_b_out = cs_b_q;
   assign flash_output_enable_b_out = oe_b_q;
   assign write_enable_b_out = we_b_q;
   // No per-lane strobes: one write enable covers all bytes
   assign mem_data_oe_out = !we_b_q;
   assign mem_data_upper_half_out = wdata_q[rcsc_pkg::DATA_W-1:
      rcsc_pkg::HALF_W];
   assign mem_data_lower_half_out = wdata_q[rcsc_pkg::HALF_W-1:0];
   assign mem_addr_out = addr_q;
   assign byte_wide_out = byte_q && busy_out;
   // Low strobe in the chosen cycle of the access
   assign mid_cycle_addr_strobe_b_out = !t_strobe;

   // Assertions
   sequence s_start;
      start_w;
   endsequence
   sequence s_cs_on;
      (rom_chip_select_b_out != rcsc_pkg::CS_IDLE);
   endsequence
   // Every chip select negated again
   sequence s_cs_off;
      (rom_chip_select_b_out == rcsc_pkg::CS_IDLE);
   endsequence

   a_one_cs_only: assert property (@(posedge clock_in) disable iff (!rst_b)
      $onehot0(~rom_chip_select_b_out))
      else $error("more than one chip select low");
   a_boot_cs_zero: assert property (@(posedge clock_in) disable iff (!rst_b)
      s_start and boot_q |=> !rom_chip_select_b_out[0])
      else $error("boot access not on chip select zero");
   a_byte_cs_low: assert property (@(posedge clock_in) disable iff (!rst_b)
      byte_wide_out |-> (rom_chip_select_b_out[3:2] == 2'h3))
      else $error("byte mode on upper chip select");
   a_lat_length: assert property (@(posedge clock_in) disable iff (!rst_b)
      s_start and rom_access_latency_in == 4'h0
      |=> s_cs_on ##1 s_cs_off)
      else $error("single cycle access wrong length");
   a_lat_two: assert property (@(posedge clock_in) disable iff (!rst_b)
      s_start and rom_access_latency_in == 4'h1
      |=> s_cs_on [*2] ##1 s_cs_off)
      else $error("two cycle access wrong length");
   a_addr_stable: assert property (@(posedge clock_in) disable iff (!rst_b)
      busy_out && !start_w && $past(busy_out) |-> $stable(mem_addr_out))
      else $error("address moved during access");
   a_read_latch: assert property (@(posedge clock_in) disable iff (!rst_b)
      t_last && !wr_q |=> rdata_out == {$past(mem_data_upper_half_in),
      $past(mem_data_lower_half_in)})
      else $error("read data not latched");
   a_strobe_inside: assert property (@(posedge clock_in) disable iff (!rst_b)
      !mid_cycle_addr_strobe_b_out |-> s_cs_on and !boot_q)
      else $error("strobe outside an access");
   a_done_after: assert property (@(posedge clock_in) disable iff (!rst_b)
      s_start |-> ##[1:17] done_out)
      else $error("access did not finish");
endmodule

//--- verification/rcsc_rom_io_model.sv
`timescale 1ns/1ns
// Behavioural ROM, flash or I/O device sitting on all four chip selects
module rcsc_rom_io_model (
   input wire logic clock_in,
   input wire logic [3:0] cs_b_in,
   input wire logic oe_b_in,
   input wire logic we_b_in,
   input wire logic [31:0] upper_in,
   input wire logic [31:0] lower_in,
   input wire logic [22:0] addr_in,
   input wire logic strobe_b_in,
   output logic [22:0] addr_seen_out,
   output logic [31:0] upper_out,
   output logic [31:0] lower_out
);
   // One full-width word per chip select, no narrower device here
   logic [63:0] mem [4];
   // Last word driven, kept so a released bus never repeats it
   logic [63:0] last_q;
   // Index of the selected device, -1 when none
   int sel;
   // Word on the bus
   logic [63:0] bus;
   // Address captured on the strobe, cleared while nothing is selected
   logic [22:0] addr_seen_q;

   // Known contents so a boot read has a fixed answer
   initial begin
      for (int i = 0; i < 4; i++) begin
         mem[i] = 64'h8877665544332211 + 64'(i);
      end
      last_q = 64'h0;
   end

   // Find the selected device
   always_comb begin
      sel = -1;
      for (int i = 0; i < 4; i++) begin
         if (cs_b_in[i] == 1'b0) begin
            sel = i;
         end
      end
   end

   // Drive only while selected and output enabled, else inverse of last
   always_comb begin
      if (sel >= 0 && oe_b_in == 1'b0) begin
         bus = mem[sel];
      end else begin
         bus = ~last_q;
      end
   end
   assign upper_out = bus[63:32];
   assign lower_out = bus[31:0];
   assign addr_seen_out = addr_seen_q;

   // Multiplexed device: latch the address on the low strobe
   always @(posedge clock_in) begin
      if (sel < 0) begin
         addr_seen_q <= 23'h0;
      end else if (strobe_b_in == 1'b0) begin
         addr_seen_q <= addr_in;
      end
   end

   // Writes land only in the device whose own select is low
   always @(posedge clock_in) begin
      if (sel >= 0 && we_b_in == 1'b0) begin
         mem[sel] <= {upper_in, lower_in};
      end
      if (sel >= 0 && oe_b_in == 1'b0) begin
         last_q <= mem[sel];
      end
   end
endmodule

//--- verification/rcsc_rom_cs_ctrl_test.sv
`timescale 1ns/1ns
// Self-checking bench for the ROM and I/O chip-select controller
module rcsc_rom_cs_ctrl_test;
   logic clock_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic req_in = 1'b0;
   logic write_in = 1'b0;
   logic [1:0] cs_sel_in = 2'h0;
   logic byte_mode_in = 1'b0;
   logic [22:0] addr_in = 23'h0;
   logic [63:0] wdata_in = 64'h0;
   logic [3:0] lat_in = 4'h0;
   logic config_done_in = 1'b0;
   logic strobe_en_in = 1'b0;
   logic [3:0] strobe_pos_in = 4'h0;
   // Device side wires
   logic [31:0] up_rd, lo_rd, up_wr, lo_wr;
   logic busy_out, done_out, fo_b, we_b, strb_b, bw_out, doe;
   logic [22:0] seen_addr;
   logic [63:0] rdata_out;
   logic [3:0] cs_b;
   logic [22:0] maddr;
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;

   rcsc_rom_cs_ctrl #(.ADDR_W(23)) u_dut (
      .clock_in(clock_in), .rst_b_in(rst_b_in), .req_in(req_in),
      .write_in(write_in), .cs_sel_in(cs_sel_in),
      .byte_mode_in(byte_mode_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .rom_access_latency_in(lat_in),
      .config_done_in(config_done_in), .strobe_en_in(strobe_en_in),
      .strobe_pos_in(strobe_pos_in), .mem_data_upper_half_in(up_rd),
      .mem_data_lower_half_in(lo_rd), .busy_out(busy_out),
      .done_out(done_out), .rdata_out(rdata_out),
      .rom_chip_select_b_out(cs_b), .flash_output_enable_b_out(fo_b),
      .write_enable_b_out(we_b), .mid_cycle_addr_strobe_b_out(strb_b),
      .byte_wide_out(bw_out), .mem_addr_out(maddr),
      .mem_data_upper_half_out(up_wr), .mem_data_lower_half_out(lo_wr),
      .mem_data_oe_out(doe));

   rcsc_rom_io_model u_dev (
      .clock_in(clock_in), .cs_b_in(cs_b), .oe_b_in(fo_b),
      .we_b_in(we_b), .upper_in(up_wr), .lower_in(lo_wr),
      .addr_in(maddr), .strobe_b_in(strb_b),
      .addr_seen_out(seen_addr),
      .upper_out(up_rd), .lower_out(lo_rd));

   // Free-running 10 MHz clock
   initial forever #50 clock_in = ~clock_in;

   // Hang guard, well above the hundred or so cycles the tests need
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         finish_test();
      end
   end

   // One comparison, counted, and reported at once if it fails
   task automatic chk(input bit ok, input string msg);
      checks_done++;
      if (!ok) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   // One access from the negedge of the request to the done pulse
   task automatic access(input logic wr, input logic [1:0] cs,
      input logic bm, input logic [3:0] lat, input logic en,
      input logic [3:0] pos, input logic [63:0] wd, input int exp_cs,
      input int exp_sp, input logic exp_bw);
      int n;
      int sp;
      logic bw;
      bit ok;
      n = 0;
      sp = -1;
      bw = 1'b0;
      ok = 1'b1;
      req_in = 1'b1;
      write_in = wr;
      cs_sel_in = cs;
      byte_mode_in = bm;
      addr_in = {18'h0, cs, 3'h5};
      wdata_in = wd;
      lat_in = lat;
      strobe_en_in = en;
      strobe_pos_in = pos;
      @(negedge clock_in);
      req_in = 1'b0;
      // Settings move mid-access; only later accesses may see them
      lat_in = ~lat;
      strobe_pos_in = ~pos;
      strobe_en_in = !en;
      // Bounded wait, walk each access cycle
      for (int k = 0; k < 40 && done_out !== 1'b1; k++) begin
         if (cs_b !== 4'hF) begin
            n++;
            ok &= cs_b === ~(4'h1 << exp_cs) && maddr === addr_in;
            ok &= busy_out === 1'b1;
            if (wr) begin
               ok &= we_b === 1'b0 && fo_b === 1'b1 && doe === 1'b1;
               ok &= up_wr === wd[63:32] && lo_wr === wd[31:0];
            end else begin
               ok &= fo_b === 1'b0 && we_b === 1'b1;
            end
         end
         if (strb_b === 1'b0) begin
            sp = n - 1;
         end
         bw |= bw_out;
         @(negedge clock_in);
      end
      chk(done_out === 1'b1, "no done pulse");
      chk(busy_out === 1'b0, "busy after done");
      chk(seen_addr === (exp_sp >= 0 ? addr_in : 23'h0), "addr seen");
      chk(n == int'(lat) + 1, "access length");
      chk(ok, "pin pattern during access");
      chk(sp == exp_sp, "strobe position");
      chk(bw === exp_bw, "byte-wide flag");
      if (!wr) begin
         chk(rdata_out === wd, "read word");
         chk(rdata_out[63:56] === wd[63:56], "byte 0 lane");
      end
   endtask

   // Before configuration: cs 0 forced, no strobe
   task automatic test_boot();
      access(1'b0, 2'h2, 1'b0, 4'h2, 1'b1, 4'h0,
         64'h8877665544332211, 0, -1, 1'b0);
      $display("test_boot finished");
   endtask

   // Every chip select, write then read back, length tracks latency
   task automatic test_cs_all();
      logic [63:0] wd;
      config_done_in = 1'b1;
      @(negedge clock_in);
      config_done_in = 1'b0;
      for (int i = 0; i < 4; i++) begin
         wd = 64'h1122334455667788 + 64'(i);
         access(1'b1, 2'(i), 1'b1, 4'(i), 1'b1, 4'h1, wd, i,
            (i > 0) ? 1 : -1, i < 2);
         access(1'b0, 2'(i), 1'b1, 4'(i), 1'b1, 4'h1, wd, i,
            (i > 0) ? 1 : -1, i < 2);
      end
      $display("test_cs_all finished");
   endtask

   // Back-to-back reads with the latency rewritten between them
   task automatic test_latency();
      logic [63:0] wd;
      wd = 64'h1122334455667788 + 64'h3;
      access(1'b0, 2'h3, 1'b0, 4'hF, 1'b1, 4'hF, wd, 3, 15, 1'b0);
      access(1'b0, 2'h3, 1'b0, 4'h0, 1'b1, 4'h0, wd, 3, 0, 1'b0);
      access(1'b0, 2'h3, 1'b0, 4'h5, 1'b1, 4'h6, wd, 3, -1, 1'b0);
      access(1'b0, 2'h3, 1'b0, 4'h5, 1'b0, 4'h2, wd, 3, -1, 1'b0);
      $display("test_latency finished");
   endtask

   // Mid-run reset: pins go idle and boot forcing comes back
   task automatic test_reset();
      @(negedge clock_in);
      rst_b_in = 1'b0;
      @(negedge clock_in);
      chk(cs_b === 4'hF, "chip selects in reset");
      chk(fo_b === 1'b1 && we_b === 1'b1, "enables in reset");
      chk(strb_b === 1'b1 && doe === 1'b0, "strobe in reset");
      chk(busy_out === 1'b0 && done_out === 1'b0, "busy in reset");
      rst_b_in = 1'b1;
      repeat (4) @(negedge clock_in);
      // Word left in device zero by the write pass
      access(1'b0, 2'h1, 1'b1, 4'h1, 1'b1, 4'h0,
         64'h1122334455667788, 0, -1, 1'b1);
      $display("test_reset finished");
   endtask

   // Counts, verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Reset for 20 cycles, settle, then the scenarios
   initial begin
      repeat (20) @(negedge clock_in);
      rst_b_in = 1'b1;
      repeat (4) @(negedge clock_in);
      test_boot();
      test_cs_all();
      test_latency();
      test_reset();
      finish_test();
   end
endmodule
